//--- design/wake_timer.sv
/*
 Wake-up down-counter on the low-frequency oscillator with AXI4-Lite
 registers. Assumes the card detection sequence and trim logic sit
 outside and answer detect_done / card_found on clk.
*/
`timescale 1ns/1ns
//Contract
// - Timer wakes system, may launch detection
// - Active bit reads running, writes start/stop
// - Run change needs run_change_enable set
// - Auto trim starts trimming on underflow
// - Auto detect starts detection on underflow
// - Card found raises interrupt, stays active
// - No card returns to power down
// - Auto reload restarts from reload value
// - Without reload or auto detect, count to zero, halt
// - Underflow sets the interrupt flag
// - Auto wake wakes on each underflow
// - Clock select divides by 1/8/16/32
// - Start event loads counter from reload
// - Reload writes wait for next start or underflow reload
// - Count high byte is readable
// - Count low byte at next index
module wake_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_freq_oscillator,
    input wire logic detect_done,
    input wire logic card_found,
    output logic wake_request,
    output logic trim_start,
    output logic card_detect_start,
    output logic power_down_request,
    output logic card_irq
);
    wake_timer_pkg::timer_state_t st;
    wake_timer_pkg::timer_state_t next_st;
    logic osc_edge;
    logic tick;
    logic uflow;
    logic wr_fire;
    logic ar_fire;
    logic ctrl_wr;
    logic start_evt;
    logic [4:0] div_last;
    logic [5:0] ar_idx;

    always_comb begin
        next_st = st;
        // Pulses last one cycle
        next_st.wake_request = 1'b0;
        next_st.trim_start = 1'b0;
        next_st.card_detect_start = 1'b0;
        next_st.power_down_request = 1'b0;
        next_st.card_irq = 1'b0;
        // Oscillator pin synchroniser and edge
        next_st.osc_s1 = low_freq_oscillator;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_s3 = st.osc_s2;
        osc_edge = st.osc_s2 && !st.osc_s3;
        case (st.wake_clk_select)
            2'h0: div_last = wake_timer_pkg::DIV_SEL0;
            2'h1: div_last = wake_timer_pkg::DIV_SEL1;
            2'h2: div_last = wake_timer_pkg::DIV_SEL2;
            default: div_last = wake_timer_pkg::DIV_SEL3;
        endcase
        tick = osc_edge && st.wake_timer_active && (st.prescale >= div_last);
        if (osc_edge && st.wake_timer_active) begin
            next_st.prescale = tick ? 5'h00 : st.prescale + 5'h01;
        end
        // decrement per tick, underflow when leaving zero
        uflow = tick && (st.count == 16'h0000);
        if (tick && !uflow) begin
            next_st.count = st.count - 16'h0001;
        end
        if (uflow) begin
            // detection mode restarts with no gap
            if (st.auto_reload || st.auto_card_detect) begin
                next_st.count = st.wake_reload_value;
            end else begin
                next_st.wake_timer_active = 1'b0;
            end
            next_st.wake_request = st.auto_wake;
            next_st.trim_start = st.auto_osc_trim;
        end
        // wake-up and detection launch on underflow
        if (uflow && st.auto_card_detect && st.detect == wake_timer_pkg::DETECT_IDLE) begin
            next_st.card_detect_start = 1'b1;
            next_st.detect = wake_timer_pkg::DETECT_BUSY;
        end
        if (st.detect == wake_timer_pkg::DETECT_BUSY && detect_done) begin
            next_st.detect = wake_timer_pkg::DETECT_IDLE;
            next_st.card_irq = card_found && st.card_irq_en;
            // no card returns to power down
            next_st.power_down_request = !card_found && st.power_down_en;
        end
        // Write channel capture
        if (st.awready && s_axi_awvalid) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = s_axi_awaddr[7:2];
        end
        if (st.wready && s_axi_wvalid) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        wr_fire = st.aw_held && st.w_held && !st.bvalid;
        ctrl_wr = wr_fire && st.w_lane0 && st.aw_idx == wake_timer_pkg::IDX_CONTROL;
        start_evt = 1'b0;
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wake_timer_pkg::RESP_OKAY;
            case (st.aw_idx)
                wake_timer_pkg::IDX_CONTROL: begin
                    if (st.w_lane0) begin
                        next_st.auto_osc_trim = st.w_data[wake_timer_pkg::BIT_AUTO_TRIM];
                        next_st.auto_card_detect = st.w_data[wake_timer_pkg::BIT_AUTO_DETECT];
                        next_st.auto_reload = st.w_data[wake_timer_pkg::BIT_AUTO_RELOAD];
                        next_st.auto_wake = st.w_data[wake_timer_pkg::BIT_AUTO_WAKE];
                        next_st.wake_clk_select = st.w_data[1:0];
                        // write starts or stops the timer
                        if (st.w_data[wake_timer_pkg::BIT_RUN_CHANGE]) begin
                            if (!st.w_data[wake_timer_pkg::BIT_ACTIVE]) begin
                                next_st.wake_timer_active = 1'b0;
                            end else if (!st.wake_timer_active) begin
                                start_evt = 1'b1;
                            end
                        end
                    end
                end
                wake_timer_pkg::IDX_RELOAD_HIGH: begin
                    if (st.w_lane0) begin
                        next_st.wake_reload_value[15:8] = st.w_data;
                    end
                end
                wake_timer_pkg::IDX_RELOAD_LOW: begin
                    if (st.w_lane0) begin
                        next_st.wake_reload_value[7:0] = st.w_data;
                    end
                end
                wake_timer_pkg::IDX_STATUS: begin
                    // Write one clears flag below
                end
                wake_timer_pkg::IDX_DETECT_CFG: begin
                    if (st.w_lane0) begin
                        next_st.card_irq_en = st.w_data[wake_timer_pkg::BIT_CARD_IRQ_EN];
                        next_st.power_down_en = st.w_data[wake_timer_pkg::BIT_POWER_DOWN_EN];
                    end
                end
                wake_timer_pkg::IDX_COUNT_HIGH, wake_timer_pkg::IDX_COUNT_LOW: begin
                    // Read-only, write ignored
                end
                default: next_st.bresp = wake_timer_pkg::RESP_SLVERR;
            endcase
        end
        // start event loads counter from reload
        if (start_evt) begin
            next_st.wake_timer_active = 1'b1;
            next_st.count = st.wake_reload_value;
            next_st.prescale = 5'h00;
        end
        // underflow sets flag, set wins over clear
        if (wr_fire && st.w_lane0 && st.aw_idx == wake_timer_pkg::IDX_STATUS
            && st.w_data[wake_timer_pkg::BIT_IRQ_FLAG]) begin
            next_st.wake_timer_irq_flag = 1'b0;
        end
        if (uflow) begin
            next_st.wake_timer_irq_flag = 1'b1;
        end
        next_st.awready = !next_st.aw_held;
        next_st.wready = !next_st.w_held;
        // Read channel
        ar_fire = st.arready && s_axi_arvalid;
        ar_idx = s_axi_araddr[7:2];
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (ar_fire) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = wake_timer_pkg::RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            case (ar_idx)
                wake_timer_pkg::IDX_CONTROL: begin
                    next_st.rdata[7:0] = {st.wake_timer_active, 1'b0, st.auto_osc_trim,
                        st.auto_card_detect, st.auto_reload, st.auto_wake,
                        st.wake_clk_select};
                end
                wake_timer_pkg::IDX_RELOAD_HIGH: next_st.rdata[7:0] = st.wake_reload_value[15:8];
                wake_timer_pkg::IDX_RELOAD_LOW: next_st.rdata[7:0] = st.wake_reload_value[7:0];
                wake_timer_pkg::IDX_COUNT_HIGH: next_st.rdata[7:0] = st.count[15:8];
                wake_timer_pkg::IDX_COUNT_LOW: next_st.rdata[7:0] = st.count[7:0];
                wake_timer_pkg::IDX_STATUS: begin
                    next_st.rdata[wake_timer_pkg::BIT_IRQ_FLAG] = st.wake_timer_irq_flag;
                    next_st.rdata[wake_timer_pkg::BIT_DETECT_BUSY] =
                        (st.detect == wake_timer_pkg::DETECT_BUSY);
                end
                wake_timer_pkg::IDX_DETECT_CFG: begin
                    next_st.rdata[wake_timer_pkg::BIT_CARD_IRQ_EN] = st.card_irq_en;
                    next_st.rdata[wake_timer_pkg::BIT_POWER_DOWN_EN] = st.power_down_en;
                end
                default: next_st.rresp = wake_timer_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.wake_clk_select <= wake_timer_pkg::RESET_CONTROL[1:0];
            st.wake_reload_value <= wake_timer_pkg::RESET_RELOAD;
            st.card_irq_en <= wake_timer_pkg::RESET_DETECT_CFG[0];
            st.power_down_en <= wake_timer_pkg::RESET_DETECT_CFG[1];
            st.detect <= wake_timer_pkg::DETECT_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign wake_request = st.wake_request;
    assign trim_start = st.trim_start;
    assign card_detect_start = st.card_detect_start;
    assign power_down_request = st.power_down_request;
    assign card_irq = st.card_irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_run_hold: assert property (
        wr_fire && st.aw_idx == wake_timer_pkg::IDX_CONTROL
        && !st.w_data[wake_timer_pkg::BIT_RUN_CHANGE] && !uflow
        |=> st.wake_timer_active == $past(st.wake_timer_active))
        else $error("running bit changed without enable");
    chk_uflow_flag: assert property (
        uflow |=> st.wake_timer_irq_flag)
        else $error("underflow did not set flag");
    chk_wake_pulse: assert property (
        uflow && st.auto_wake |=> wake_request ##1 !wake_request)
        else $error("wake pulse wrong");
    chk_reload_restart: assert property (
        uflow && (st.auto_reload || st.auto_card_detect) && !ctrl_wr
        |=> st.wake_timer_active && st.count == $past(st.wake_reload_value))
        else $error("no reload on underflow");
    chk_halt_zero: assert property (
        uflow && !st.auto_reload && !st.auto_card_detect && !ctrl_wr
        |=> !st.wake_timer_active && st.count == 16'h0000)
        else $error("timer did not halt");
    chk_trim_launch: assert property (
        uflow && st.auto_osc_trim |=> trim_start)
        else $error("trim not launched");
    chk_detect_launch: assert property (
        uflow && st.auto_card_detect && st.detect == wake_timer_pkg::DETECT_IDLE
        |=> card_detect_start && st.detect == wake_timer_pkg::DETECT_BUSY)
        else $error("detection not launched");
    chk_start_load: assert property (
        start_evt |=> st.wake_timer_active && st.count == $past(st.wake_reload_value))
        else $error("start did not load reload");
    chk_count_step: assert property (
        tick && !uflow && !start_evt |=> st.count == $past(st.count) - 16'h0001)
        else $error("count did not decrement");
    chk_count_read: assert property (
        ar_fire && ar_idx == wake_timer_pkg::IDX_COUNT_HIGH
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.count[15:8]))
        else $error("count high read wrong");
endmodule : wake_timer

//--- design/wake_timer_pkg.sv
/*
 Constants, state enum and state struct of the wake-up timer.
 Assumes an AXI4-Lite slave with register index = byte address / 4.
*/
package wake_timer_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h23;
    localparam logic [5:0] IDX_RELOAD_HIGH = 6'h24;
    localparam logic [5:0] IDX_RELOAD_LOW = 6'h25;
    localparam logic [5:0] IDX_COUNT_HIGH = 6'h26;
    localparam logic [5:0] IDX_COUNT_LOW = 6'h27;
    localparam logic [5:0] IDX_STATUS = 6'h28;
    localparam logic [5:0] IDX_DETECT_CFG = 6'h29;
    // Control fields
    localparam int BIT_ACTIVE = 7;
    localparam int BIT_RUN_CHANGE = 6;
    localparam int BIT_AUTO_TRIM = 5;
    localparam int BIT_AUTO_DETECT = 4;
    localparam int BIT_AUTO_RELOAD = 3;
    localparam int BIT_AUTO_WAKE = 2;
    // Status and detect config fields
    localparam int BIT_IRQ_FLAG = 0;
    localparam int BIT_DETECT_BUSY = 1;
    localparam int BIT_CARD_IRQ_EN = 0;
    localparam int BIT_POWER_DOWN_EN = 1;
    // Reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [15:0] RESET_RELOAD = 16'h0000;
    localparam logic [1:0] RESET_DETECT_CFG = 2'h0;
    // Divider minus one per clock select code
    localparam logic [4:0] DIV_SEL0 = 5'h00;
    localparam logic [4:0] DIV_SEL1 = 5'h07;
    localparam logic [4:0] DIV_SEL2 = 5'h0f;
    localparam logic [4:0] DIV_SEL3 = 5'h1f;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {DETECT_IDLE, DETECT_BUSY} detect_state_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [5:0] aw_idx;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic [4:0] prescale;
        logic wake_timer_active;
        logic auto_osc_trim;
        logic auto_card_detect;
        logic auto_reload;
        logic auto_wake;
        logic [1:0] wake_clk_select;
        logic [15:0] wake_reload_value;
        logic [15:0] count;
        logic wake_timer_irq_flag;
        logic card_irq_en;
        logic power_down_en;
        detect_state_t detect;
        logic wake_request;
        logic trim_start;
        logic card_detect_start;
        logic power_down_request;
        logic card_irq;
    } timer_state_t;
endpackage : wake_timer_pkg

//--- verif/tb_wake_timer.sv
/*
 Self-checking bench for the wake-up timer: register access over AXI4-Lite,
 oscillator edges, clock dividers, reload, wake, trim and detection pulses.
 Assumes the detection sequence outside is played by the bench.
*/
`timescale 1ns/1ns
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_wake_timer;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic low_freq_oscillator = 1'b0;
    logic detect_done = 1'b0;
    logic card_found = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic wake_request, trim_start, card_detect_start, power_down_request, card_irq;
    int fails = 0;
    int checks_done = 0;
    int n_wake = 0;
    int n_trim = 0;
    int n_det = 0;
    int n_pd = 0;
    int n_cirq = 0;
    int d;

    wake_timer uut (
        .clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .low_freq_oscillator(low_freq_oscillator), .detect_done(detect_done),
        .card_found(card_found), .wake_request(wake_request), .trim_start(trim_start),
        .card_detect_start(card_detect_start), .power_down_request(power_down_request),
        .card_irq(card_irq)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // Count output pulses
    always @(posedge clk) begin
        if (wake_request === 1'b1) n_wake++;
        if (trim_start === 1'b1) n_trim++;
        if (card_detect_start === 1'b1) n_det++;
        if (power_down_request === 1'b1) n_pd++;
        if (card_irq === 1'b1) n_cirq++;
    end

    task automatic test_done();
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic wr(input logic [5:0] idx, input logic [7:0] data,
                      input logic [1:0] exp_resp = 2'h0);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, data};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHECK(s_axi_bresp, exp_resp)
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic chk_read(input logic [5:0] idx, input logic [7:0] exp_data,
                            input logic [1:0] exp_resp = 2'h0);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        `CHECK(s_axi_rdata, {24'h0, exp_data})
        `CHECK(s_axi_rresp, exp_resp)
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : chk_read

    // Oscillator edges, slow against clk so the synchroniser sees each one
    task automatic osc_pulses(input int n);
        repeat (n) begin
            low_freq_oscillator <= 1'b1;
            repeat (4) @(posedge clk);
            low_freq_oscillator <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : osc_pulses

    task automatic finish_detect(input logic found);
        detect_done <= 1'b1;
        card_found <= found;
        @(posedge clk);
        detect_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : finish_detect

    initial begin
        #500000;
        fails++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk_read(6'h23, 8'h00);
        chk_read(6'h24, 8'h00);
        chk_read(6'h25, 8'h00);
        chk_read(6'h26, 8'h00);
        chk_read(6'h27, 8'h00);
        chk_read(6'h30, 8'h00, 2'h2);
        wr(6'h30, 8'h55, 2'h2);
        wr(6'h25, 8'h03);
        wr(6'h23, 8'h80);
        chk_read(6'h23, 8'h00);
        wr(6'h23, 8'hc0);
        chk_read(6'h23, 8'h80);
        chk_read(6'h27, 8'h03);
        wr(6'h25, 8'h09);
        chk_read(6'h27, 8'h03);
        wr(6'h26, 8'hff);
        chk_read(6'h26, 8'h00);
        osc_pulses(3);
        chk_read(6'h27, 8'h00);
        chk_read(6'h23, 8'h80);
        osc_pulses(1);
        chk_read(6'h23, 8'h00);
        chk_read(6'h27, 8'h00);
        chk_read(6'h28, 8'h01);
        `CHECK(n_wake, 0)
        wr(6'h28, 8'h01);
        chk_read(6'h28, 8'h00);
        wr(6'h25, 8'h01);
        for (int sel = 0; sel < 4; sel++) begin
            d = (sel == 0) ? 1 : (4 << sel);
            wr(6'h23, 8'hec | 8'(sel));
            osc_pulses(2 * d - 1);
            chk_read(6'h27, 8'h00);
            `CHECK(n_wake, sel)
            osc_pulses(1);
            chk_read(6'h27, 8'h01);
            `CHECK(n_wake, sel + 1)
            `CHECK(n_trim, sel + 1)
            chk_read(6'h23, 8'hac | 8'(sel));
            wr(6'h23, 8'h40);
            chk_read(6'h23, 8'h00);
        end
        wr(6'h28, 8'h01);
        wr(6'h29, 8'h03);
        wr(6'h23, 8'hd4);
        osc_pulses(2);
        `CHECK(n_det, 1)
        chk_read(6'h23, 8'h94);
        chk_read(6'h27, 8'h01);
        chk_read(6'h28, 8'h03);
        finish_detect(1'b0);
        `CHECK(n_pd, 1)
        `CHECK(n_cirq, 0)
        chk_read(6'h28, 8'h01);
        osc_pulses(2);
        `CHECK(n_det, 2)
        finish_detect(1'b1);
        `CHECK(n_cirq, 1)
        `CHECK(n_pd, 1)
        `CHECK(n_wake, 6)
        `CHECK(n_trim, 4)
        wr(6'h23, 8'h40);
        chk_read(6'h23, 8'h00);
        wr(6'h24, 8'h12);
        chk_read(6'h24, 8'h12);
        wr(6'h23, 8'hc0);
        chk_read(6'h26, 8'h12);
        chk_read(6'h27, 8'h01);
        wr(6'h23, 8'h00);
        chk_read(6'h23, 8'h80);
        wr(6'h23, 8'h40);
        chk_read(6'h23, 8'h00);
        test_done();
    end
endmodule : tb_wake_timer
